// ===== verilog/bxe_exec.sv
/*
 bxe_exec: fetch, decode and execute of the six exclusive_or_op forms.
 Assumes code and data memory answer a read in the same cycle as the
 registered request, and take a write on the edge that ends it.
*/
`default_nettype none
module bxe_exec
    import bxe_pkg::*;
#(
    parameter logic [7:0] PORT_ONE_ADDR = PORT_ONE_ADDR_DEF
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // control
    input  wire logic        start_in,
    input  wire logic [1:0]  bank_sel_in,
    input  wire logic        pc_load_in,
    input  wire logic [15:0] pc_in,
    input  wire logic        acc_wr_in,
    input  wire logic [7:0]  acc_wdata_in,
    // program memory
    input  wire logic [7:0]  code_data_in,
    output logic             code_rd_out,
    output logic      [15:0] code_addr_out,
    // data memory and port
    input  wire logic [7:0]  data_rdata_in,
    input  wire logic [7:0]  port_one_latch_in,
    output var bxe_dreq_s    data_req_out,
    // status
    output logic      [7:0]  acc_out,
    output logic      [15:0] pc_out,
    output logic             busy_out,
    output logic             done_out,
    output logic             illegal_out,
    output logic      [1:0]  instr_bytes_out,
    output logic      [1:0]  instr_cycles_out
);
    bxe_state_e  st_ff, nxt_st;
    bxe_form_e   form_ff, dec_form;
    bxe_dreq_s   dreq_ff, nxt_dreq;
    logic [7:0]  dir_ff, opnd_ff, mask_ff, acc_ff;
    logic [15:0] pc_ff, nxt_pc, code_addr_ff, nxt_code_addr;
    logic        code_rd_ff, nxt_code_rd;
    logic        done_ff, ill_ff, busy_ff;
    logic [1:0]  bytes_ff, cyc_ff;
    logic        dest_dir, use_latch;
    logic [7:0]  opnd_sel, xor_y, xor_b;

    function automatic bxe_form_e decode(input logic [7:0] op);
        bxe_form_e f;
        f = F_BAD;
        if (op[7:3] == OPC_BANK_HI) begin
            f = F_BANK;
        end else if (op[7:1] == OPC_IND_HI) begin
            f = F_IND;
        end else begin
            case (op)
                OPC_A_DIR: f = F_DIR;
                OPC_A_IMM: f = F_IMM;
                OPC_D_ACC: f = F_DA;
                OPC_D_IMM: f = F_DI;
                default:   f = F_BAD;
            endcase
        end
        return f;
    endfunction : decode

    assign dec_form  = decode(code_data_in);
    assign dest_dir  = (form_ff == F_DA) || (form_ff == F_DI);
    assign use_latch = dest_dir && (dir_ff == PORT_ONE_ADDR);
    // direct,#data uses the mask; every other form mixes in the accumulator
    assign xor_b     = (form_ff == F_DI) ? mask_ff : acc_ff;

    bxe_xor_unit u_xor (
        .mem_in       (data_rdata_in),
        .latch_in     (port_one_latch_in),
        .use_latch_in (use_latch),
        .a_in         (opnd_ff),
        .b_in         (xor_b),
        .opnd_out     (opnd_sel),
        .y_out        (xor_y)
    );

    always_comb begin
        nxt_st        = st_ff;
        nxt_pc        = pc_ff;
        nxt_code_rd   = 1'b0;
        nxt_code_addr = code_addr_ff;
        nxt_dreq      = '0;
        case (st_ff)
            ST_IDLE: begin
                if (start_in) begin
                    nxt_code_rd   = 1'b1;
                    nxt_code_addr = pc_ff;
                    nxt_pc        = pc_ff + 16'h0001;
                    nxt_st        = ST_OP;
                end
            end
            ST_OP: begin
                case (dec_form)
                    F_BANK: begin
                        nxt_dreq.rd   = 1'b1;
                        nxt_dreq.addr = {3'h0, bank_sel_in, code_data_in[2:0]};
                        nxt_st        = ST_RD;
                    end
                    F_IND: begin
                        nxt_dreq.rd   = 1'b1;
                        nxt_dreq.addr = {3'h0, bank_sel_in, 2'h0, code_data_in[0]};
                        nxt_st        = ST_PTR;
                    end
                    F_BAD: nxt_st = ST_IDLE;
                    default: begin
                        nxt_code_rd   = 1'b1;
                        nxt_code_addr = pc_ff;
                        nxt_pc        = pc_ff + 16'h0001;
                        nxt_st        = ST_B2;
                    end
                endcase
            end
            ST_B2: begin
                case (form_ff)
                    F_IMM: nxt_st = ST_EXEC;
                    F_DI: begin
                        nxt_code_rd   = 1'b1;
                        nxt_code_addr = pc_ff;
                        nxt_pc        = pc_ff + 16'h0001;
                        nxt_st        = ST_B3;
                    end
                    default: begin
                        nxt_dreq.rd   = 1'b1;
                        nxt_dreq.addr = code_data_in;
                        nxt_st        = ST_RD;
                    end
                endcase
            end
            ST_B3: begin
                nxt_dreq.rd   = 1'b1;
                nxt_dreq.addr = dir_ff;
                nxt_st        = ST_RD;
            end
            ST_PTR: begin
                nxt_dreq.rd   = 1'b1;
                nxt_dreq.addr = data_rdata_in;
                nxt_st        = ST_RD;
            end
            ST_RD: nxt_st = ST_EXEC;
            ST_EXEC: begin
                if (dest_dir) begin
                    nxt_dreq.wr    = 1'b1;
                    nxt_dreq.addr  = dir_ff;
                    nxt_dreq.wdata = xor_y;
                end
                nxt_st = ST_IDLE;
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    // sequencer and memory requests
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff        <= ST_IDLE;
            code_rd_ff   <= 1'b0;
            code_addr_ff <= PC_RST;
            dreq_ff      <= '0;
            busy_ff      <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            code_rd_ff   <= nxt_code_rd;
            code_addr_ff <= nxt_code_addr;
            dreq_ff      <= nxt_dreq;
            busy_ff      <= (nxt_st != ST_IDLE);
        end
    end

    // program counter; a load only while idle so a fetch never races it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_ff <= PC_RST;
        end else if ((st_ff == ST_IDLE) && pc_load_in && !start_in) begin
            pc_ff <= pc_in;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // operand capture
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            form_ff <= F_BAD;
            dir_ff  <= 8'h00;
            opnd_ff <= 8'h00;
            mask_ff <= 8'h00;
        end else begin
            case (st_ff)
                ST_OP: form_ff <= dec_form;
                ST_B2: begin
                    dir_ff <= code_data_in;
                    if (form_ff == F_IMM) begin
                        opnd_ff <= code_data_in;
                    end
                end
                ST_B3: mask_ff <= code_data_in;
                ST_RD: opnd_ff <= opnd_sel;
                default: ;
            endcase
        end
    end

    // accumulator: written when it is the destination or by acc_wr_in while idle, no flag path
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_ff <= ACC_RST;
        end else if ((st_ff == ST_EXEC) && !dest_dir) begin
            acc_ff <= xor_y;
        end else if ((st_ff == ST_IDLE) && acc_wr_in) begin
            acc_ff <= acc_wdata_in;
        end
    end

    // completion status
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_ff  <= 1'b0;
            ill_ff   <= 1'b0;
            bytes_ff <= 2'h0;
            cyc_ff   <= 2'h0;
        end else begin
            done_ff <= (st_ff == ST_EXEC);
            ill_ff  <= (st_ff == ST_OP) && (dec_form == F_BAD);
            if (st_ff == ST_EXEC) begin
                case (form_ff)
                    F_BANK, F_IND: bytes_ff <= LEN_ONE;
                    F_DI:        bytes_ff <= LEN_THREE;
                    default:     bytes_ff <= LEN_TWO;
                endcase
                cyc_ff <= (form_ff == F_DI) ? CYC_TWO : CYC_ONE;
            end
        end
    end

    assign code_rd_out      = code_rd_ff;
    assign code_addr_out    = code_addr_ff;
    assign data_req_out     = dreq_ff;
    assign acc_out          = acc_ff;
    assign pc_out           = pc_ff;
    assign busy_out         = busy_ff;
    assign done_out         = done_ff;
    assign illegal_out      = ill_ff;
    assign instr_bytes_out  = bytes_ff;
    assign instr_cycles_out = cyc_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_done3;
        ##3 done_out && (instr_cycles_out == CYC_ONE);
    endsequence
    sequence s_done4;
        ##4 done_out && (instr_bytes_out == LEN_TWO);
    endsequence

    AST_BANK_FORM: assert property ((st_ff == ST_OP) && (code_data_in[7:3] == OPC_BANK_HI)
        |-> s_done3 and ##3 (pc_out == $past(pc_out, 3)) && (instr_bytes_out == LEN_ONE))
        else $error("bank register form length or timing wrong");
    AST_DIR_FORM: assert property ((st_ff == ST_OP) && (code_data_in == OPC_A_DIR)
        |-> s_done4 and ##4 (pc_out == $past(pc_out, 4) + 16'h0001))
        else $error("direct source form length or timing wrong");
    AST_IND_FORM: assert property ((st_ff == ST_OP) && (code_data_in[7:1] == OPC_IND_HI)
        |=> data_req_out.rd && (data_req_out.addr[0] == $past(code_data_in[0]))
            ##3 done_out && (instr_bytes_out == LEN_ONE))
        else $error("indirect form pointer or timing wrong");
    AST_IMM_FORM: assert property ((st_ff == ST_OP) && (code_data_in == OPC_A_IMM)
        |-> ##3 done_out && (acc_out == ($past(acc_ff, 3) ^ $past(code_data_in, 2))))
        else $error("immediate form result wrong");
    AST_DA_KEEP_ACC: assert property (data_req_out.wr && (form_ff == F_DA)
        |-> (acc_out == $past(acc_out)) && (data_req_out.addr == dir_ff)
            && (data_req_out.wdata == ($past(opnd_ff) ^ acc_out)))
        else $error("direct write result wrong or accumulator changed");
    AST_DI_FORM: assert property ((st_ff == ST_OP) && (code_data_in == OPC_D_IMM)
        |-> ##5 done_out && (instr_bytes_out == LEN_THREE) && (instr_cycles_out == CYC_TWO)
            && (pc_out == $past(pc_out, 5) + 16'h0002))
        else $error("direct immediate form length or timing wrong");
    AST_PORT_LATCH: assert property ((st_ff == ST_RD) && dest_dir && (dir_ff == PORT_ONE_ADDR)
        |=> opnd_ff == $past(port_one_latch_in))
        else $error("port destination not read from latch");
    AST_MASK_WRITE: assert property ((st_ff == ST_EXEC) && (form_ff == F_DI)
        |=> data_req_out.wr && (data_req_out.addr == $past(dir_ff))
            && (data_req_out.wdata == ($past(opnd_ff) ^ $past(mask_ff))))
        else $error("mask write to direct byte wrong");
    AST_ACC_ONLY: assert property ((st_ff == ST_EXEC) && !dest_dir
        |=> !data_req_out.wr && (acc_out == ($past(opnd_ff) ^ $past(acc_ff))))
        else $error("accumulator destination result misplaced");
    AST_DA_FORM: assert property ((st_ff == ST_OP) && (code_data_in == OPC_D_ACC)
        |-> ##4 done_out && data_req_out.wr && (instr_bytes_out == LEN_TWO))
        else $error("direct accumulator form timing wrong");
    AST_PC_FETCH: assert property (code_rd_out |-> pc_out == code_addr_out + 16'h0001)
        else $error("program counter not advanced past fetched byte");
endmodule : bxe_exec
`default_nettype wire

// ===== verilog/bxe_pkg.sv
/*
 bxe_pkg: opcodes, forms, states, lengths, cycle counts and the data
 memory request carrier of the exclusive_or_op execution block.
 Assumes one core clock; memories answer reads combinationally.
*/
`default_nettype none
package bxe_pkg;
    // opcode encodings
    localparam logic [4:0] OPC_BANK_HI = 5'h0D;
    localparam logic [6:0] OPC_IND_HI = 7'h33;
    localparam logic [7:0] OPC_A_DIR  = 8'h65;
    localparam logic [7:0] OPC_A_IMM  = 8'h64;
    localparam logic [7:0] OPC_D_ACC  = 8'h62;
    localparam logic [7:0] OPC_D_IMM  = 8'h63;
    // byte address of the port one latch (plain default)
    localparam logic [7:0] PORT_ONE_ADDR_DEF = 8'h90;
    // instruction lengths and machine cycles
    localparam logic [1:0] LEN_ONE   = 2'h1;
    localparam logic [1:0] LEN_TWO   = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    // reset values
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [15:0] PC_RST  = 16'h0000;

    typedef enum logic [6:0] {
        F_BANK = 7'h01,
        F_DIR = 7'h02,
        F_IND = 7'h04,
        F_IMM = 7'h08,
        F_DA  = 7'h10,
        F_DI  = 7'h20,
        F_BAD = 7'h40
    } bxe_form_e;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_OP   = 8'h02,
        ST_B2   = 8'h04,
        ST_B3   = 8'h08,
        ST_PTR  = 8'h10,
        ST_RD   = 8'h20,
        ST_EXEC = 8'h40,
        ST_SPARE = 8'h80
    } bxe_state_e;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bxe_dreq_s;
endpackage : bxe_pkg
`default_nettype wire

// ===== verilog/bxe_xor_unit.sv
/*
 bxe_xor_unit: destination operand select and the byte-wide XOR.
 Assumes the caller registers the outputs; purely combinational.
*/
`default_nettype none
module bxe_xor_unit (
    // operand sources
    input  wire logic [7:0] mem_in,
    input  wire logic [7:0] latch_in,
    input  wire logic       use_latch_in,
    // xor operands
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    // results
    output logic      [7:0] opnd_out,
    output logic      [7:0] y_out
);
    // read-modify-write of a port must start from the latch, not the pins
    assign opnd_out = use_latch_in ? latch_in : mem_in;
    assign y_out    = a_in ^ b_in;
endmodule : bxe_xor_unit
`default_nettype wire

// ===== tb/bxe_mem_model.sv
/*
 bxe_mem_model: program memory, internal data memory and port one latch
 facing bxe_exec. Assumes reads answer combinationally in the request
 cycle and writes land on the edge that ends the write pulse.
*/
`default_nettype none
module bxe_mem_model
    import bxe_pkg::*;
#(
    parameter logic [7:0] PORT_ADDR = PORT_ONE_ADDR_DEF
) (
    // clock
    input  wire logic        clk_in,
    // program memory
    input  wire logic        code_rd_in,
    input  wire logic [15:0] code_addr_in,
    output logic      [7:0]  code_data_out,
    // data memory and port
    input  wire bxe_dreq_s   data_req_in,
    output logic      [7:0]  data_rdata_out,
    output logic      [7:0]  port_one_latch_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] code_mem [256];
    logic [7:0] data_mem [256];
    logic [7:0] latch_ff = 8'h00;
    logic [7:0] code_last_ff = 8'h00;
    logic [7:0] data_last_ff = 8'h00;
    // outside a read the bus toggles, so a stale byte is never mistaken for data
    assign code_data_out = code_rd_in ? code_mem[code_addr_in[7:0]] : ~code_last_ff;
    assign data_rdata_out = data_req_in.rd ? data_mem[data_req_in.addr] : ~data_last_ff;
    assign port_one_latch_out = latch_ff;
    always @(posedge clk_in) begin
        code_last_ff <= code_data_out;
        data_last_ff <= data_rdata_out;
    end
    // port writes reach the latch only; data_mem at the port address are the pins
    always @(posedge clk_in) begin
        if (data_req_in.wr === 1'b1) begin
            if (data_req_in.addr == PORT_ADDR) begin
                latch_ff <= data_req_in.wdata;
            end else begin
                data_mem[data_req_in.addr] <= data_req_in.wdata;
            end
        end
    end
endmodule : bxe_mem_model
`default_nettype wire

// ===== tb/tb.sv
/*
 tb: directed scenarios for bxe_exec, one task each.
 Assumes bxe_mem_model as program and data memory and port one latch.
*/
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bxe_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, pc_load_in = 1'b0;
    logic acc_wr_in = 1'b0, code_rd, done_out, illegal_out, busy_out;
    logic [1:0] bank_sel_in = 2'h0, nbytes, ncyc;
    logic [7:0] acc_wdata_in = 8'h00, code_data, rdata, latch, acc_out;
    logic [15:0] pc_in = 16'h0000, code_addr, pc_out, writes = 16'h0000;
    bxe_dreq_s dreq;
    int failures = 0, comparisons = 0;
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) if (dreq.wr === 1'b1) writes <= writes + 16'h0001;
    bxe_exec u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
        .bank_sel_in(bank_sel_in), .pc_load_in(pc_load_in), .pc_in(pc_in),
        .acc_wr_in(acc_wr_in), .acc_wdata_in(acc_wdata_in), .code_data_in(code_data),
        .code_rd_out(code_rd), .code_addr_out(code_addr), .data_rdata_in(rdata),
        .port_one_latch_in(latch), .data_req_out(dreq), .acc_out(acc_out),
        .pc_out(pc_out), .busy_out(busy_out), .done_out(done_out),
        .illegal_out(illegal_out), .instr_bytes_out(nbytes), .instr_cycles_out(ncyc));
    bxe_mem_model u_mem (.clk_in(clk_in), .code_rd_in(code_rd), .code_addr_in(code_addr),
        .code_data_out(code_data), .data_req_in(dreq), .data_rdata_out(rdata),
        .port_one_latch_out(latch));
    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic setup(input logic [15:0] pc, input logic [7:0] acc);
        @(posedge clk_in);
        pc_load_in <= 1'b1; pc_in <= pc; acc_wr_in <= 1'b1; acc_wdata_in <= acc;
        @(posedge clk_in);
        pc_load_in <= 1'b0; acc_wr_in <= 1'b0;
        #1;
    endtask : setup
    // poke: loads attempted while busy must be ignored
    task automatic run(input logic [1:0] nb, input logic [1:0] nc, input logic ill,
                       input logic poke, input logic [15:0] nwr);
        logic [15:0] pc0, w0;
        int n;
        pc0 = pc_out; w0 = writes; n = 0;
        @(posedge clk_in); start_in <= 1'b1;
        @(posedge clk_in); start_in <= 1'b0;
        if (poke) begin
            acc_wr_in <= 1'b1; acc_wdata_in <= 8'hEE; pc_load_in <= 1'b1; pc_in <= 16'hBEEF;
        end
        #1;
        check(16'(busy_out), 16'h0001);
        while (n < 20 && done_out !== 1'b1 && illegal_out !== 1'b1) begin
            @(posedge clk_in); acc_wr_in <= 1'b0; pc_load_in <= 1'b0;
            #1; n++;
        end
        if (n == 20) begin failures++; give_verdict(); end
        check(16'(illegal_out), 16'(ill));
        check(pc_out, pc0 + 16'(nb));
        if (!ill) begin
            check(16'(nbytes), 16'(nb));
            check(16'(ncyc), 16'(nc));
        end
        @(posedge clk_in); #1;
        check(writes - w0, nwr);
        check(16'({busy_out, done_out, illegal_out}), 16'h0000);
    endtask : run
    task automatic s_bank;
        for (int r = 0; r < 8; r++) begin
            u_mem.code_mem[8'h10 + 8'(r)] = 8'h68 | 8'(r);
            u_mem.data_mem[8'h10 + 8'(r)] = 8'hAA ^ 8'(r);
            bank_sel_in <= 2'h2;
            setup(16'h0010 + 16'(r), 8'hC3);
            run(2'h1, 2'h1, 1'b0, 1'b0, 16'h0000);
            check(16'(acc_out), 16'(8'h69 ^ 8'(r)));
        end
        $display("test bank register done");
    endtask : s_bank
    task automatic s_dir;
        u_mem.code_mem[8'hFE] = 8'h65; u_mem.code_mem[8'hFF] = 8'h45;
        u_mem.data_mem[8'h45] = 8'h3C;
        setup(16'h12FE, 8'h0F);
        run(2'h2, 2'h1, 1'b0, 1'b1, 16'h0000);
        check(16'(acc_out), 16'h0033);
        check(16'(u_mem.data_mem[8'h45]), 16'h003C);
        $display("test direct source done");
    endtask : s_dir
    task automatic s_ind;
        for (int i = 0; i < 2; i++) begin
            u_mem.code_mem[8'h20 + 8'(i)] = 8'h66 | 8'(i);
            u_mem.data_mem[8'h08 + 8'(i)] = 8'h30 + 8'(i);
            u_mem.data_mem[8'h30 + 8'(i)] = 8'h5A ^ 8'(i + 4);
            bank_sel_in <= 2'h1;
            setup(16'h0020 + 16'(i), 8'h00);
            run(2'h1, 2'h1, 1'b0, 1'b0, 16'h0000);
            check(16'(acc_out), 16'(8'h5A ^ 8'(i + 4)));
        end
        $display("test pointer register done");
    endtask : s_ind
    task automatic s_imm;
        u_mem.code_mem[8'h30] = 8'h64; u_mem.code_mem[8'h31] = 8'hFF;
        setup(16'h0030, 8'hC3);
        run(2'h2, 2'h1, 1'b0, 1'b1, 16'h0000);
        check(16'(acc_out), 16'h003C);
        $display("test immediate done");
    endtask : s_imm
    task automatic s_da;
        u_mem.code_mem[8'h40] = 8'h62; u_mem.code_mem[8'h41] = 8'h2F;
        u_mem.code_mem[8'h42] = 8'h62; u_mem.code_mem[8'h43] = 8'h90;
        u_mem.data_mem[8'h2F] = 8'h0F; u_mem.data_mem[8'h90] = 8'h0F;
        u_mem.latch_ff = 8'hF0;
        setup(16'h0040, 8'h55);
        run(2'h2, 2'h1, 1'b0, 1'b0, 16'h0001);
        check(16'(u_mem.data_mem[8'h2F]), 16'h005A);
        run(2'h2, 2'h1, 1'b0, 1'b0, 16'h0001);
        check(16'(u_mem.latch_ff), 16'h00A5);
        check(16'(acc_out), 16'h0055);
        $display("test direct from accumulator done");
    endtask : s_da
    task automatic s_di;
        logic [7:0] mask [3] = '{8'h31, 8'h00, 8'hFF};
        logic [7:0] dst [3] = '{8'h90, 8'h7F, 8'h7F};
        logic [7:0] exp [3] = '{8'h94, 8'hC6, 8'h39};
        u_mem.latch_ff = 8'hA5; u_mem.data_mem[8'h90] = 8'h5A; u_mem.data_mem[8'h7F] = 8'hC6;
        setup(16'h0050, 8'h77);
        for (int k = 0; k < 3; k++) begin
            u_mem.code_mem[8'h50 + 8'(3 * k)] = 8'h63;
            u_mem.code_mem[8'h51 + 8'(3 * k)] = dst[k];
            u_mem.code_mem[8'h52 + 8'(3 * k)] = mask[k];
            run(2'h3, 2'h2, 1'b0, 1'b0, 16'h0001);
            if (k == 0) check(16'(u_mem.latch_ff), 16'(exp[k]));
            else check(16'(u_mem.data_mem[8'h7F]), 16'(exp[k]));
        end
        check(16'(acc_out), 16'h0077);
        $display("test direct with mask done");
    endtask : s_di
    task automatic s_bad;
        u_mem.code_mem[8'h60] = 8'h60;
        setup(16'h0060, 8'h12);
        run(2'h1, 2'h0, 1'b1, 1'b0, 16'h0000);
        check(16'(acc_out), 16'h0012);
        $display("test foreign opcode done");
    endtask : s_bad
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in); #1;
        check({acc_out, 7'h00, busy_out}, 16'h0000);
        check(pc_out, 16'h0000);
        check(16'({done_out, illegal_out, code_rd, dreq.rd, dreq.wr, nbytes, ncyc}), 16'h0000);
        s_bank(); s_dir(); s_ind(); s_imm(); s_da(); s_di(); s_bad();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
